// file: core/gmpu_move_permute.sv
// move, predicate, user mask, permute and or execution unit
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// Overview of operation
// - indexed file reads use only index bits 7:0
// - missing indexed register faults, except in performance file
// - implementation part of performance file reads fault only on tagged index
// - instruction pointer move writes executing bundle address
// - predicate i lands in bit i, bit zero reads one
// - predicate zero stays one, never written
// - register predicate write gated by 17-bit mask from 16-bit field
// - mask top bit covers all rotating predicates
// - tagged source on register predicate write faults
// - rotate form writes predicates 16..63 from sign-extended immediate
// - predicate moves act as if rotation base were zero
// - user mask read zero-extends status bits 5:0
// - user mask write replaces only status bits 5:0
// - long immediate writes 64 bits, 41 from long slot
// - byte permute offers exactly five patterns
// - reverse puts byte 0 on top, byte 7 at bottom
// - broadcast copies byte 0 to all bytes
// - mix, shuffle and alternate byte orders as listed
// - halfword j takes halfword named by selector bits 2j+1:2j
// - no-operation changes nothing, marker immediate ignored
// - long-slot no-operation accepts upper 41 immediate bits
// - unit no-operation forms only run on their unit type
// - or combines register or immediate with second operand
// - or immediate sign-extended, tag from used sources
module gmpu_move_permute #(
    parameter int IDX_COUNT     = 8,
    parameter int PMD_COUNT     = 256,
    parameter logic [5:0] UM_RESERVED = 6'h01
) (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          nrst,
    // issue
    input  wire gmpu_pkg::gmpu_issue_t         issue,
    // indexed file read port
    output      logic [7:0]                    idxAddr,
    output      gmpu_pkg::gmpu_file_t          idxFile,
    input  wire logic [gmpu_pkg::GR_WIDTH-1:0] idxData,
    // predicate and status state
    input  wire logic [gmpu_pkg::PRED_COUNT-1:0] predIn,
    input  wire logic [gmpu_pkg::GR_WIDTH-1:0]   psrIn,
    // results
    output      gmpu_pkg::gmpu_grwr_t          grWrite,
    output      logic                          predWriteEn,
    output      logic [gmpu_pkg::PRED_COUNT-1:0] predWriteMask,
    output      logic [gmpu_pkg::PRED_COUNT-1:0] predWriteData,
    output      logic                          umWriteEn,
    output      logic [gmpu_pkg::UM_MSB:0]     umWriteData,
    output      gmpu_pkg::gmpu_fault_t         fault
);
    import gmpu_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // reset release
    logic rstMeta;
    logic rstSync;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [63:0] sext8(input logic [7:0] v);
        sext8 = {{56{v[7]}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // qualification
    wire fire = issue.valid && issue.qp;
    wire unitOk = (issue.op != GMPU_OP_NOP) ||
                  (issue.nopUnit == issue.unit);

    ////////////////////////////////////////////////////////////////////
    // indexed file read
    wire [7:0] index = issue.srcB[INDEX_MSB:INDEX_LSB];
    wire idxRd = issue.op == GMPU_OP_IDX_READ;
    wire idxMissing = (issue.file == GMPU_FILE_ID) &&
                      ({24'h000000, index} >= IDX_COUNT);
    wire idxTagFault = idxRd && issue.srcBTag;
    wire idxResFault = idxRd && !issue.srcBTag && idxMissing;

    assign idxAddr = index;
    assign idxFile = issue.file;

    ////////////////////////////////////////////////////////////////////
    // predicates, rotation base taken as zero
    wire [63:0] predRead = {predIn[63:1], 1'b1};
    wire [16:0] mask17 = {issue.maskField, 1'b0};
    wire [63:0] regMask = {{47{mask17[16]}}, mask17};
    wire [43:0] rotImm = {issue.rotField, 16'h0000};
    wire [63:0] rotVal = {{20{rotImm[43]}}, rotImm};
    wire predRegWr = issue.op == GMPU_OP_PRED_WRITE;
    wire predRotWr = issue.op == GMPU_OP_PRED_ROT;
    wire predTagFault = predRegWr && issue.srcATag;
    wire [63:0] rotMask = {48'hFFFFFFFFFFFF, 16'h0000};
    wire [63:0] next_predMask =
        (predRotWr ? rotMask : regMask) & 64'hFFFFFFFFFFFFFFFE;
    wire [63:0] next_predData = predRotWr ? rotVal : issue.srcA;

    ////////////////////////////////////////////////////////////////////
    // user mask
    wire umWr = issue.op == GMPU_OP_UM_WRITE;
    wire umTagFault = umWr && issue.srcATag;
    wire umResFault = umWr && !issue.srcATag &&
                      ((issue.srcA[UM_MSB:0] & UM_RESERVED) != 6'h00);
    wire [63:0] umRead = {58'h0, psrIn[UM_MSB:0]};

    ////////////////////////////////////////////////////////////////////
    // long immediate, permute, or
    wire [63:0] longImm = {issue.longSlot, issue.longLow};
    wire [63:0] permRes;
    gmpu_byte_perm permNet (
        .bperm    (issue.bperm),
        .halfSel  (issue.halfSel),
        .halfMode (issue.op == GMPU_OP_HALF_PERM),
        .src      (issue.srcA),
        .result   (permRes)
    );
    wire orImm = issue.op == GMPU_OP_OR_IMM;
    wire [63:0] orA = orImm ? sext8(issue.imm8) : issue.srcA;
    wire [63:0] orRes = orA | issue.srcB;
    wire orTag = issue.srcBTag || (!orImm && issue.srcATag);

    ////////////////////////////////////////////////////////////////////
    // result selection
    logic [63:0] resData;
    logic        resTag;
    logic        resWr;
    always_comb begin
        resData = 64'h0;
        resTag  = 1'b0;
        resWr   = 1'b1;
        unique case (issue.op)
            GMPU_OP_IDX_READ:  resData = idxData;
            GMPU_OP_IP_READ:   resData = issue.bundleIp;
            GMPU_OP_PRED_READ: resData = predRead;
            GMPU_OP_UM_READ:   resData = umRead;
            GMPU_OP_LONG_IMM:  resData = longImm;
            GMPU_OP_BYTE_PERM, GMPU_OP_HALF_PERM: begin
                resData = permRes;
                resTag  = issue.srcATag;
            end
            GMPU_OP_OR_REG, GMPU_OP_OR_IMM: begin
                resData = orRes;
                resTag  = orTag;
            end
            GMPU_OP_NOP, GMPU_OP_PRED_WRITE, GMPU_OP_PRED_ROT,
            GMPU_OP_UM_WRITE:  resWr = 1'b0;
            default:           resWr = 1'b0;
        endcase
    end

    wire anyFault = idxTagFault || idxResFault || predTagFault ||
                    umTagFault || umResFault || !unitOk;
    wire commit = fire && !anyFault;

    ////////////////////////////////////////////////////////////////////
    // output registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            grWrite       <= '0;
            predWriteEn   <= 1'b0;
            predWriteMask <= 64'h0;
            predWriteData <= 64'h0;
            umWriteEn     <= 1'b0;
            umWriteData   <= 6'h00;
            fault         <= '0;
        end else if (!rstSync) begin
            grWrite       <= '0;
            predWriteEn   <= 1'b0;
            umWriteEn     <= 1'b0;
            fault         <= '0;
        end else begin
            grWrite.valid <= commit && resWr;
            grWrite.data  <= resData;
            grWrite.tag   <= resTag;
            predWriteEn   <= commit && (predRegWr || predRotWr);
            predWriteMask <= next_predMask;
            predWriteData <= next_predData;
            umWriteEn     <= commit && umWr;
            umWriteData   <= issue.srcA[UM_MSB:0];
            fault.tagConsume <= fire &&
                (idxTagFault || predTagFault || umTagFault);
            fault.reservedRegField <= fire &&
                (idxResFault || umResFault);
            fault.illegalUnit <= fire && !unitOk;
        end
    end
endmodule

// file: core/gmpu_pkg.sv
// package for the move and permute execution unit
package gmpu_pkg;

    localparam int GR_WIDTH      = 64;
    localparam int PRED_COUNT    = 64;
    localparam int INDEX_LSB     = 0;
    localparam int INDEX_MSB     = 7;
    localparam int UM_MSB        = 5;
    localparam int MASK17_WIDTH  = 17;
    localparam int MASK_FIELD_W  = 16;
    localparam int ROT_FIELD_W   = 28;
    localparam int ROT_IMM_W     = 44;
    localparam int ROT_SHIFT     = 16;
    localparam int ROT_FIRST     = 16;
    localparam int LONG_SLOT_W   = 41;
    localparam int LONG_LOW_W    = 23;
    localparam int HALF_SEL_W    = 8;
    localparam int IMM8_W        = 8;
    localparam int PMD_IMPL_BASE = 4;

    typedef enum logic [4:0] {
        GMPU_OP_NOP,
        GMPU_OP_IDX_READ,
        GMPU_OP_IP_READ,
        GMPU_OP_PRED_READ,
        GMPU_OP_PRED_WRITE,
        GMPU_OP_PRED_ROT,
        GMPU_OP_UM_READ,
        GMPU_OP_UM_WRITE,
        GMPU_OP_LONG_IMM,
        GMPU_OP_BYTE_PERM,
        GMPU_OP_HALF_PERM,
        GMPU_OP_OR_REG,
        GMPU_OP_OR_IMM
    } gmpu_op_t;

    typedef enum logic [2:0] {
        GMPU_BP_REV,
        GMPU_BP_MIX,
        GMPU_BP_SHUF,
        GMPU_BP_ALT,
        GMPU_BP_BRCST
    } gmpu_bperm_t;

    typedef enum logic [1:0] {
        GMPU_FILE_ID,
        GMPU_FILE_PMD
    } gmpu_file_t;

    typedef enum logic [2:0] {
        GMPU_UNIT_I,
        GMPU_UNIT_B,
        GMPU_UNIT_M,
        GMPU_UNIT_F,
        GMPU_UNIT_X
    } gmpu_unit_t;

    // one issued operation
    typedef struct packed {
        logic        valid;
        gmpu_op_t    op;
        logic        qp;
        gmpu_unit_t  unit;
        gmpu_unit_t  nopUnit;
        gmpu_file_t  file;
        gmpu_bperm_t bperm;
        logic [HALF_SEL_W-1:0]   halfSel;
        logic [MASK_FIELD_W-1:0] maskField;
        logic [ROT_FIELD_W-1:0]  rotField;
        logic [LONG_LOW_W-1:0]   longLow;
        logic [LONG_SLOT_W-1:0]  longSlot;
        logic [IMM8_W-1:0]       imm8;
        logic [GR_WIDTH-1:0]     srcA;
        logic                    srcATag;
        logic [GR_WIDTH-1:0]     srcB;
        logic                    srcBTag;
        logic [GR_WIDTH-1:0]     bundleIp;
    } gmpu_issue_t;

    // general register write back
    typedef struct packed {
        logic                valid;
        logic [GR_WIDTH-1:0] data;
        logic                tag;
    } gmpu_grwr_t;

    // fault report
    typedef struct packed {
        logic tagConsume;
        logic reservedRegField;
        logic illegalUnit;
    } gmpu_fault_t;

endpackage

// file: core/gmpu_byte_perm.sv
// byte and halfword permute network
`timescale 1ns/100ps
module gmpu_byte_perm (
    // selection
    input  wire gmpu_pkg::gmpu_bperm_t              bperm,
    input  wire logic [gmpu_pkg::HALF_SEL_W-1:0]    halfSel,
    input  wire logic                               halfMode,
    // data
    input  wire logic [gmpu_pkg::GR_WIDTH-1:0]      src,
    output      logic [gmpu_pkg::GR_WIDTH-1:0]      result
);
    import gmpu_pkg::*;

    wire [7:0] b0 = src[7:0];
    wire [7:0] b1 = src[15:8];
    wire [7:0] b2 = src[23:16];
    wire [7:0] b3 = src[31:24];
    wire [7:0] b4 = src[39:32];
    wire [7:0] b5 = src[47:40];
    wire [7:0] b6 = src[55:48];
    wire [7:0] b7 = src[63:56];

    function automatic logic [15:0] pickHalf(input logic [63:0] s,
                                             input logic [1:0]  idx);
        pickHalf = s[idx*16 +: 16];
    endfunction

    wire [63:0] revRes  = {b0, b1, b2, b3, b4, b5, b6, b7};
    wire [63:0] mixRes  = {b7, b3, b5, b1, b6, b2, b4, b0};
    wire [63:0] shufRes = {b7, b3, b6, b2, b5, b1, b4, b0};
    wire [63:0] altRes  = {b7, b5, b3, b1, b6, b4, b2, b0};
    wire [63:0] brcRes  = {8{b0}};
    wire [63:0] halfRes = {pickHalf(src, halfSel[7:6]),
                           pickHalf(src, halfSel[5:4]),
                           pickHalf(src, halfSel[3:2]),
                           pickHalf(src, halfSel[1:0])};

    wire [63:0] byteRes =
        (bperm == GMPU_BP_REV)  ? revRes  :
        (bperm == GMPU_BP_MIX)  ? mixRes  :
        (bperm == GMPU_BP_SHUF) ? shufRes :
        (bperm == GMPU_BP_ALT)  ? altRes  : brcRes;

    assign result = halfMode ? halfRes : byteRes;
endmodule

// file: bench/gmpu_move_permute_sva.sv
// assertions on the move and permute unit ports
`timescale 1ns/100ps
module gmpu_move_permute_sva
    import gmpu_pkg::*;
(
    // clock and reset
    input wire logic                          clock,
    input wire logic                          nrst,
    // watched ports
    input wire gmpu_pkg::gmpu_issue_t         issue,
    input wire logic [7:0]                    idxAddr,
    input wire logic [gmpu_pkg::GR_WIDTH-1:0] predIn,
    input wire logic [gmpu_pkg::GR_WIDTH-1:0] psrIn,
    input wire gmpu_pkg::gmpu_grwr_t          grWrite,
    input wire logic                          predWriteEn,
    input wire logic [gmpu_pkg::GR_WIDTH-1:0] predWriteMask,
    input wire gmpu_pkg::gmpu_fault_t         fault
);
    logic [1:0] up;
    // two edges of sync reset before issues count
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            up <= 2'h0;
        else
            up <= {up[0], 1'b1};
    end
    wire logic go = up[1] && issue.valid && issue.qp;
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!nrst);
    AST_OR_REG: assert property (go && issue.op == GMPU_OP_OR_REG |=>
        grWrite.valid && grWrite.data == ($past(issue.srcA) | $past(issue.srcB)))
        else $error("or register result wrong");
    AST_OR_IMM: assert property (go && issue.op == GMPU_OP_OR_IMM |=>
        grWrite.data[7:0] == ($past(issue.imm8) | $past(issue.srcB[7:0]))
        && grWrite.tag == $past(issue.srcBTag)) else $error("or imm wrong");
    AST_QP_OFF: assert property (issue.valid && !issue.qp |=>
        !grWrite.valid && !predWriteEn && fault == '0)
        else $error("effect with false predicate");
    AST_IDX_ADDR: assert property (issue.op == GMPU_OP_IDX_READ |->
        idxAddr == issue.srcB[7:0]) else $error("index address wrong");
    AST_PRED_RD: assert property (go && issue.op == GMPU_OP_PRED_READ |=>
        grWrite.data == ($past(predIn) | 64'h1) && !grWrite.tag)
        else $error("predicate read wrong");
    AST_UM_RD: assert property (go && issue.op == GMPU_OP_UM_READ |=>
        grWrite.data == ($past(psrIn) & 64'h3F)) else $error("mask read wrong");
    AST_PRED0: assert property (predWriteEn |-> !predWriteMask[0])
        else $error("predicate zero written");
    AST_ROT: assert property (go && issue.op == GMPU_OP_PRED_ROT |=>
        predWriteEn && predWriteMask == 64'hFFFF_FFFF_FFFF_0000)
        else $error("rotate mask wrong");
    AST_LONG: assert property (go && issue.op == GMPU_OP_LONG_IMM |=>
        grWrite.data == {$past(issue.longSlot), $past(issue.longLow)})
        else $error("long immediate wrong");
    AST_TAG_PW: assert property (go && issue.op == GMPU_OP_PRED_WRITE
        && issue.srcATag |=> fault.tagConsume && !predWriteEn)
        else $error("tagged predicate write not faulted");
endmodule

// file: bench/gmpu_idx_model.sv
// indexed register file model
`timescale 1ns/100ps
module gmpu_idx_model
    import gmpu_pkg::*;
(
    // lookup
    input  wire logic [7:0]              idxAddr,
    input  wire gmpu_pkg::gmpu_file_t    idxFile,
    // read data
    output logic [gmpu_pkg::GR_WIDTH-1:0] idxData
);
    // file code on top, index echoed low
    assign idxData = {(idxFile == GMPU_FILE_PMD) ? 8'hC2 : 8'hC1,
                      48'h0, idxAddr};
endmodule

// file: bench/gmpu_move_permute_tb.sv
// self-checking bench for the move and permute unit
`timescale 1ns/100ps
module gmpu_move_permute_tb;
    import gmpu_pkg::*;
    logic        clock, nrst, predWriteEn, umWriteEn;
    gmpu_issue_t issue, i;
    logic [7:0]  idxAddr;
    gmpu_file_t  idxFile;
    logic [63:0] idxData, predIn, psrIn, predV, psrV, predWriteMask;
    logic [63:0] predWriteData;
    gmpu_grwr_t  grWrite;
    logic [5:0]  umWriteData;
    gmpu_fault_t fault;
    int          num_errors = 0, tests_run = 0, cycles = 0;
    gmpu_move_permute dut (.clock, .nrst, .issue, .idxAddr, .idxFile,
        .idxData, .predIn, .psrIn, .grWrite, .predWriteEn, .predWriteMask,
        .predWriteData, .umWriteEn, .umWriteData, .fault);
    gmpu_idx_model far (.idxAddr, .idxFile, .idxData);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            num_errors++;
            stop_test();
        end
    end
    ////////////////////////////////////////
    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [63:0] e, g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic gr(input logic v, input logic [63:0] d, input logic t,
                      input logic [2:0] f);
        chk("grValid", v, grWrite.valid);
        if (v) begin
            chk("grData", d, grWrite.data);
            chk("grTag", t, grWrite.tag);
        end
        chk("fault", f, fault);
    endtask
    task automatic run(input gmpu_op_t op);
        i.op = op;
        @(posedge clock);
        issue <= i;
        predIn <= predV;
        psrIn <= psrV;
        @(posedge clock);
        issue <= '0;
        #1;
    endtask
    task automatic fresh;
        i = '0;
        i.valid = 1'b1;
        i.qp = 1'b1;
    endtask
    ////////////////////////////////////////
    task automatic t_or;
        fresh();
        i.srcA = 64'hF0F0_0000_0000_000F;
        i.srcB = 64'h0F00_0000_0000_00F0;
        i.srcATag = 1'b1;
        run(GMPU_OP_OR_REG);
        gr(1, 64'hFFF0_0000_0000_00FF, 1, 0);
        i.imm8 = 8'h81;
        run(GMPU_OP_OR_IMM);
        gr(1, 64'hFFFF_FFFF_FFFF_FFF1, 0, 0);
        i.qp = 1'b0;
        run(GMPU_OP_OR_REG);
        gr(0, 0, 0, 0);
    endtask
    task automatic t_idx;
        fresh();
        i.srcB = 64'hFFFF_0000_0000_0F03;
        run(GMPU_OP_IDX_READ);
        gr(1, 64'hC100_0000_0000_0003, 0, 0);
        i.srcB = 64'h8;
        run(GMPU_OP_IDX_READ);
        gr(0, 0, 0, 3'h2);
        i.file = GMPU_FILE_PMD;
        i.srcB = 64'hFF;
        run(GMPU_OP_IDX_READ);
        gr(1, 64'hC200_0000_0000_00FF, 0, 0);
        i.srcBTag = 1'b1;
        run(GMPU_OP_IDX_READ);
        gr(0, 0, 0, 3'h4);
        i.bundleIp = 64'h0000_4000_1234_5670;
        run(GMPU_OP_IP_READ);
        gr(1, 64'h0000_4000_1234_5670, 0, 0);
        i.longSlot = 41'h100_0000_0001;
        i.longLow = 23'h7F_FFFE;
        run(GMPU_OP_LONG_IMM);
        gr(1, 64'h8000_0000_00FF_FFFE, 0, 0);
    endtask
    task automatic t_pred;
        fresh();
        predV = 64'hAAAA_5555_AAAA_5554;
        run(GMPU_OP_PRED_READ);
        gr(1, 64'hAAAA_5555_AAAA_5555, 0, 0);
        i.maskField = 16'h8001;
        i.srcA = 64'h5A5A_5A5A_5A5A_FFFF;
        run(GMPU_OP_PRED_WRITE);
        chk("pMask", 64'hFFFF_FFFF_FFFF_0002, predWriteMask);
        chk("pEn", 1, predWriteEn);
        chk("pData", 64'h5A5A_5A5A_5A5A_0002, predWriteData & predWriteMask);
        i.maskField = 16'h0003;
        run(GMPU_OP_PRED_WRITE);
        chk("pMask", 64'h6, predWriteMask);
        i.srcATag = 1'b1;
        run(GMPU_OP_PRED_WRITE);
        chk("pEn", 0, predWriteEn);
        chk("pFault", 64'h4, fault);
        i.rotField = 28'h800_0001;
        run(GMPU_OP_PRED_ROT);
        chk("rData", 64'hFFFF_F800_0001_0000, predWriteData & predWriteMask);
        chk("rMask", 64'hFFFF_FFFF_FFFF_0000, predWriteMask);
        chk("rEn", 1, predWriteEn);
    endtask
    task automatic t_um;
        fresh();
        psrV = 64'hFFFF_FFFF_FFFF_FFE6;
        run(GMPU_OP_UM_READ);
        gr(1, 64'h26, 0, 0);
        i.srcA = 64'hFFFF_FFFF_FFFF_FFFE;
        run(GMPU_OP_UM_WRITE);
        chk("um", 64'h7E, {umWriteEn, umWriteData});
        i.srcA = 64'h1;
        run(GMPU_OP_UM_WRITE);
        chk("um", 64'h2, {umWriteEn, fault});
        i.srcATag = 1'b1;
        run(GMPU_OP_UM_WRITE);
        chk("um", 64'h4, {umWriteEn, fault});
        i.qp = 1'b0;
        run(GMPU_OP_UM_WRITE);
        chk("um", 64'h0, {umWriteEn, fault});
    endtask
    task automatic t_perm;
        logic [63:0] pat [5] = '{64'h1011_1213_1415_1617,
            64'h1713_1511_1612_1410, 64'h1713_1612_1511_1410,
            64'h1715_1311_1614_1210, 64'h1010_1010_1010_1010};
        fresh();
        i.srcA = 64'h1716_1514_1312_1110;
        i.srcATag = 1'b1;
        for (int k = 0; k < 5; k++) begin
            i.bperm = gmpu_bperm_t'(k);
            run(GMPU_OP_BYTE_PERM);
            gr(1, pat[k], 1, 0);
        end
        i.halfSel = 8'h1B;
        run(GMPU_OP_HALF_PERM);
        gr(1, 64'h1110_1312_1514_1716, 1, 0);
        i.halfSel = 8'h0C;
        run(GMPU_OP_HALF_PERM);
        gr(1, 64'h1110_1110_1716_1110, 1, 0);
    endtask
    task automatic t_nop;
        fresh();
        i.longSlot = '1;
        i.longLow = '1;
        for (int k = 0; k < 5; k++) begin
            i.unit = gmpu_unit_t'(k);
            i.nopUnit = gmpu_unit_t'(k);
            run(GMPU_OP_NOP);
            chk("nop", 0, {grWrite.valid, predWriteEn, umWriteEn, fault});
            i.nopUnit = gmpu_unit_t'((k + 1) % 5);
            run(GMPU_OP_NOP);
            chk("nop", 1, {grWrite.valid, predWriteEn, umWriteEn, fault});
        end
    endtask
    initial begin
        nrst = 1'b0;
        issue = '0;
        predV = '0;
        psrV = '0;
        predIn = '0;
        psrIn = '0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        t_or();
        t_idx();
        t_pred();
        t_um();
        t_perm();
        t_nop();
        stop_test();
    end
endmodule
bind gmpu_move_permute gmpu_move_permute_sva sva (.clock, .nrst, .issue,
    .idxAddr, .predIn, .psrIn, .grWrite, .predWriteEn, .predWriteMask,
    .fault);
